// *** src/led_pin_consts.svh ***
// offsets, field positions, reset values and timing counts of the indicator and pin block
`ifndef LED_PIN_CONSTS_SVH
`define LED_PIN_CONSTS_SVH
`define ADDR_IND0_CTL1 16'h0806
`define ADDR_IND0_CTL2 16'h0807
`define ADDR_IND1_CTL1 16'h0808
`define ADDR_IND1_CTL2 16'h0809
`define ADDR_SENSE_PD 16'h082D
`define ADDR_IND0_PD 16'h082F
`define ADDR_SENSE_DIR 16'h0831
`define ADDR_IND0_DIR 16'h0833
`define ADDR_SENSE_OUT 16'h0835
`define ADDR_IND0_OUT 16'h0837
`define RST_BYTE 8'h00
`define POL_BIT 7
`define MODE_BIT 6
`define PERIOD_MSB 5
`define TRAIL_MSB 7
`define TRAIL_LSB 2
`define RUN_BIT 1
`define FUNC_BIT 0
`define IND0_BIT 0
`define SENSE_MSB 4
`define FIELD_W 6
`define CLK_PERIOD_NS 10
`define BLINK_STEP_MS 50
`define BREATH_STEP_MS 500
// half a blink step is the common tick
`define TICK_MS (`BLINK_STEP_MS / 2)
`define TICK_CYCLES (`TICK_MS * 1000000 / `CLK_PERIOD_NS)
`define TICKS_PER_BREATH (`BREATH_STEP_MS / `TICK_MS)
`define PRESC_W 22
`define PHASE_W 11
`define LEVEL_STEP 8'h19
`endif

// *** src/led_pin_pkg.sv ***
// types shared by the indicator and pin block
`include "led_pin_consts.svh"
package led_pin_pkg;
   typedef logic [7:0] byte_t;
   typedef logic [15:0] addr_t;
   typedef logic [`SENSE_MSB:0] sense_vec_t;
   typedef enum logic [2:0] {
      PS_IDLE = 3'b000,
      PS_BLINK_ON = 3'b001,
      PS_BLINK_OFF = 3'b010,
      PS_BREATH = 3'b011,
      PS_SLEEP = 3'b100
   } pat_state_t;
   typedef struct packed {
      pat_state_t state;
      logic [`PRESC_W-1:0] presc;
      logic [`PHASE_W-1:0] phase;
      logic [`PHASE_W-1:0] trail;
      logic trailing;
      byte_t level;
      byte_t pwm;
      logic run_d;
      logic wave;
   } pat_regs_t;
   typedef struct packed {
      byte_t ind0_ctl1;
      byte_t ind0_ctl2;
      byte_t ind1_ctl1;
      byte_t ind1_ctl2;
      byte_t sense_pd;
      byte_t ind0_pd;
      byte_t sense_dir;
      byte_t ind0_dir;
      byte_t sense_dat;
      byte_t ind0_dat;
      byte_t rdata;
      logic rvalid;
      sense_vec_t sense_out;
      sense_vec_t sense_oe;
      sense_vec_t sense_pd_en;
      logic ind0_out;
      logic ind0_oe;
      logic ind0_pd_en;
      logic ind1_out;
      logic ind1_oe;
   } top_regs_t;
endpackage : led_pin_pkg

// *** src/pattern_if.sv ***
// link between the register side and one pattern generator
`timescale 1ns/1ps
`default_nettype none
`include "led_pin_consts.svh"
interface pattern_if;
   logic mode;
   logic run;
   logic [`FIELD_W-1:0] period;
   logic [`FIELD_W-1:0] trail;
   logic wave;
   modport ctrl (output mode, output run, output period, output trail, input wave);
   modport gen (input mode, input run, input period, input trail, output wave);
endinterface : pattern_if
`default_nettype wire

// *** src/pattern_gen.sv ***
// blink and breathe pattern generator for one indicator
`timescale 1ns/1ps
`default_nettype none
`include "led_pin_consts.svh"
module pattern_gen #(
   parameter logic [`PRESC_W-1:0] TICK_CYCLES = `PRESC_W'(`TICK_CYCLES)
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // pattern control
   pattern_if.gen pif
);
   import led_pin_pkg::*;
   pat_regs_t s_r;
   pat_regs_t s_nxt;
   logic tick;
   logic blinking;
   logic [`PHASE_W-1:0] half_len;
   logic [`PHASE_W-1:0] breath_len;
   logic [`PHASE_W-1:0] sleep_len;
   logic [`PHASE_W-1:0] phase_inc;

   always_comb begin
      s_nxt = s_r;
      tick = (s_r.presc == TICK_CYCLES - 1'b1);
      // a zero period is held at the shortest step
      half_len = `PHASE_W'((pif.period == '0) ? 1 : pif.period);
      breath_len = `PHASE_W'(half_len * `TICKS_PER_BREATH);
      sleep_len = `PHASE_W'(pif.trail * `TICKS_PER_BREATH);
      phase_inc = s_r.phase + 1'b1;
      blinking = (s_r.state == PS_BLINK_ON) || (s_r.state == PS_BLINK_OFF);
      s_nxt.run_d = pif.run;
      s_nxt.pwm = s_r.pwm + 8'h01;
      s_nxt.presc = tick ? '0 : s_r.presc + 1'b1;
      if (tick)
         s_nxt.phase = phase_inc;
      case (s_r.state)
         PS_BLINK_ON, PS_BLINK_OFF: begin
            if (tick && phase_inc >= half_len) begin
               s_nxt.phase = '0;
               s_nxt.state = (s_r.state == PS_BLINK_ON) ? PS_BLINK_OFF : PS_BLINK_ON;
            end
            if (tick && s_r.trailing) begin
               s_nxt.trail = s_r.trail - 1'b1;
               if (s_r.trail == `PHASE_W'(1)) begin
                  s_nxt.state = PS_IDLE;
                  s_nxt.trailing = 1'b0;
               end
            end
         end
         PS_BREATH: begin
            // linear ramp, saturating; long breaths plateau at full level
            if (tick && s_r.phase < (breath_len >> 1))
               s_nxt.level = (s_r.level > 8'hFF - `LEVEL_STEP) ? 8'hFF : s_r.level + `LEVEL_STEP;
            else if (tick)
               s_nxt.level = (s_r.level < `LEVEL_STEP) ? 8'h00 : s_r.level - `LEVEL_STEP;
            if (tick && phase_inc >= breath_len) begin
               s_nxt.phase = '0;
               s_nxt.level = 8'h00;
               s_nxt.state = (sleep_len == '0) ? PS_BREATH : PS_SLEEP;
            end
         end
         PS_SLEEP: begin
            if (tick && phase_inc >= sleep_len) begin
               s_nxt.phase = '0;
               s_nxt.state = PS_BREATH;
            end
         end
         PS_IDLE: s_nxt.phase = '0;
         default: s_nxt.state = PS_IDLE;
      endcase
      if (!pif.run && s_r.run_d) begin
         if (blinking && pif.trail != '0) begin
            s_nxt.trailing = 1'b1;
            s_nxt.trail = `PHASE_W'({pif.trail, 1'b0});
         end else begin
            s_nxt.state = PS_IDLE;
            s_nxt.trailing = 1'b0;
         end
      end
      if (pif.run && !s_r.run_d) begin
         s_nxt.presc = '0;
         s_nxt.phase = '0;
         s_nxt.trailing = 1'b0;
         s_nxt.level = 8'h00;
         s_nxt.state = pif.mode ? PS_BREATH : PS_BLINK_ON;
      end
      s_nxt.wave = (s_nxt.state == PS_BLINK_ON)
                 || ((s_nxt.state == PS_BREATH) && (s_r.pwm < s_r.level));
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   assign pif.wave = s_r.wave;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   a_restart_full: assert property ((pif.run && !s_r.run_d) |=> (s_r.presc == '0) && (s_r.phase == '0))
      else $error("timer not restarted on run");
   a_start_mode: assert property ((pif.run && !s_r.run_d && pif.mode) |=> s_r.state == PS_BREATH)
      else $error("breathe mode did not start");
   a_breath_stop: assert property ((!pif.run && s_r.run_d && !blinking) |=> s_r.state == PS_IDLE)
      else $error("breathing did not stop at once");
   a_trail_keep: assert property (
      (!pif.run && s_r.run_d && blinking && pif.trail != '0)
      |=> (s_r.state != PS_IDLE) && s_r.trailing)
      else $error("blinking stopped before trail-off");
   a_blink_toggle: assert property (
      (s_r.state == PS_BLINK_OFF && $past(s_r.state) == PS_BLINK_ON)
      |-> $past(tick))
      else $error("blink half ended off a tick");
   a_sleep_entry: assert property (
      (s_r.state == PS_SLEEP && $past(s_r.state) != PS_SLEEP)
      |-> $past(s_r.state) == PS_BREATH && $past(tick))
      else $error("sleep entered out of a breath end");
endmodule : pattern_gen
`default_nettype wire

// *** src/led_pin_io.sv ***
// indicator pattern and pin block: configuration registers, pin control, two generators
`timescale 1ns/1ps
`default_nettype none
`include "led_pin_consts.svh"
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
module led_pin_io #(
   parameter logic [`PRESC_W-1:0] TICK_CYCLES = `PRESC_W'(`TICK_CYCLES)
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // configuration register port
   input wire led_pin_pkg::addr_t cfg_addr,
   input wire led_pin_pkg::byte_t cfg_wdata,
   input wire logic cfg_wr,
   input wire logic cfg_rd,
   output led_pin_pkg::byte_t cfg_rdata,
   output logic cfg_rvalid,
   // sense pins
   output led_pin_pkg::sense_vec_t sense_out,
   output led_pin_pkg::sense_vec_t sense_oe,
   output led_pin_pkg::sense_vec_t sense_pd_en,
   // indicator pin 0
   output logic ind0_out,
   output logic ind0_oe,
   output logic ind0_pd_en,
   // indicator pin 1
   output logic ind1_out,
   output logic ind1_oe
);
   import led_pin_pkg::*;

   top_regs_t r;
   top_regs_t r_nxt;

   //////////////////////////////////////////////////////////////////////////////
   // pattern generators

   pattern_if pif0 ();
   pattern_if pif1 ();

   assign pif0.mode = r.ind0_ctl1[`MODE_BIT];
   assign pif0.period = r.ind0_ctl1[`PERIOD_MSB:0];
   assign pif0.trail = r.ind0_ctl2[`TRAIL_MSB:`TRAIL_LSB];
   assign pif0.run = r.ind0_ctl2[`RUN_BIT];

   assign pif1.mode = r.ind1_ctl1[`MODE_BIT];
   assign pif1.period = r.ind1_ctl1[`PERIOD_MSB:0];
   assign pif1.trail = r.ind1_ctl2[`TRAIL_MSB:`TRAIL_LSB];
   assign pif1.run = r.ind1_ctl2[`RUN_BIT];

   pattern_gen #(
      .TICK_CYCLES(TICK_CYCLES)
   ) u_pat0 (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .pif(pif0)
   );

   pattern_gen #(
      .TICK_CYCLES(TICK_CYCLES)
   ) u_pat1 (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .pif(pif1)
   );

   //////////////////////////////////////////////////////////////////////////////
   // register file and pin drive

   always_comb begin
      r_nxt = r;
      r_nxt.rvalid = 1'b0;
      // whole bytes are kept, reserved bits included
      if (cfg_wr) begin
         case (cfg_addr)
            `ADDR_IND0_CTL1: begin
               r_nxt.ind0_ctl1 = cfg_wdata;
            end
            `ADDR_IND0_CTL2: begin
               r_nxt.ind0_ctl2 = cfg_wdata;
            end
            `ADDR_IND1_CTL1: begin
               r_nxt.ind1_ctl1 = cfg_wdata;
            end
            `ADDR_IND1_CTL2: begin
               r_nxt.ind1_ctl2 = cfg_wdata;
            end
            `ADDR_SENSE_PD: begin
               r_nxt.sense_pd = cfg_wdata;
            end
            `ADDR_IND0_PD: begin
               r_nxt.ind0_pd = cfg_wdata;
            end
            `ADDR_SENSE_DIR: begin
               r_nxt.sense_dir = cfg_wdata;
            end
            `ADDR_IND0_DIR: begin
               r_nxt.ind0_dir = cfg_wdata;
            end
            `ADDR_SENSE_OUT: begin
               r_nxt.sense_dat = cfg_wdata;
            end
            `ADDR_IND0_OUT: begin
               r_nxt.ind0_dat = cfg_wdata;
            end
            default: begin
               r_nxt.rvalid = 1'b0;
            end
         endcase
      end
      // reads see the value before a write in the same cycle
      if (cfg_rd) begin
         r_nxt.rvalid = 1'b1;
         case (cfg_addr)
            `ADDR_IND0_CTL1: r_nxt.rdata = r.ind0_ctl1;
            `ADDR_IND0_CTL2: r_nxt.rdata = r.ind0_ctl2;
            `ADDR_IND1_CTL1: r_nxt.rdata = r.ind1_ctl1;
            `ADDR_IND1_CTL2: r_nxt.rdata = r.ind1_ctl2;
            `ADDR_SENSE_PD: r_nxt.rdata = r.sense_pd;
            `ADDR_IND0_PD: r_nxt.rdata = r.ind0_pd;
            `ADDR_SENSE_DIR: r_nxt.rdata = r.sense_dir;
            `ADDR_IND0_DIR: r_nxt.rdata = r.ind0_dir;
            `ADDR_SENSE_OUT: r_nxt.rdata = r.sense_dat;
            `ADDR_IND0_OUT: r_nxt.rdata = r.ind0_dat;
            default: r_nxt.rdata = `RST_BYTE;
         endcase
      end
      // pin outputs lag the stored bytes by one cycle so that they leave flops
      r_nxt.sense_pd_en = r.sense_pd[`SENSE_MSB:0];
      r_nxt.sense_oe = r.sense_dir[`SENSE_MSB:0];
      r_nxt.sense_out = r.sense_dat[`SENSE_MSB:0];
      r_nxt.ind0_pd_en = r.ind0_pd[`IND0_BIT];
      if (r.ind0_ctl2[`FUNC_BIT]) begin
         r_nxt.ind0_oe = 1'b1;
         r_nxt.ind0_out = pif0.wave ^ r.ind0_ctl1[`POL_BIT];
      end else begin
         r_nxt.ind0_oe = r.ind0_dir[`IND0_BIT];
         r_nxt.ind0_out = r.ind0_dat[`IND0_BIT];
      end
      // pin 1 has no plain io registers: released when not in LED mode
      if (r.ind1_ctl2[`FUNC_BIT]) begin
         r_nxt.ind1_oe = 1'b1;
         r_nxt.ind1_out = pif1.wave ^ r.ind1_ctl1[`POL_BIT];
      end else begin
         r_nxt.ind1_oe = 1'b0;
         r_nxt.ind1_out = 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n)
         r <= '0;
      else
         r <= r_nxt;
   end

   //////////////////////////////////////////////////////////////////////////////
   // outputs

   assign cfg_rdata = r.rdata;
   assign cfg_rvalid = r.rvalid;
   assign sense_out = r.sense_out;
   assign sense_oe = r.sense_oe;
   assign sense_pd_en = r.sense_pd_en;
   assign ind0_out = r.ind0_out;
   assign ind0_oe = r.ind0_oe;
   assign ind0_pd_en = r.ind0_pd_en;
   assign ind1_out = r.ind1_out;
   assign ind1_oe = r.ind1_oe;

   //////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   a_ctl1_read: assert property ((cfg_rd && cfg_addr == `ADDR_IND0_CTL1 && !cfg_wr)
      |=> cfg_rvalid && cfg_rdata == $past(r.ind0_ctl1))
      else $error("indicator 0 control one misread");
   a_write_read: assert property ((cfg_wr && cfg_addr == `ADDR_IND0_PD) ##1 !cfg_wr
      ##1 (cfg_rd && cfg_addr == `ADDR_IND0_PD && !cfg_wr)
      |=> cfg_rdata == $past(cfg_wdata, 3))
      else $error("stored byte not read back");
   a_unmapped_zero: assert property ((cfg_rd && cfg_addr == 16'h0000)
      |=> cfg_rvalid && cfg_rdata == `RST_BYTE)
      else $error("unmapped read not zero");
   a_sense_pull: assert property ((cfg_wr && cfg_addr == `ADDR_SENSE_PD)
      |-> ##2 sense_pd_en == $past(cfg_wdata[`SENSE_MSB:0], 2))
      else $error("sense pull-down not applied");
   a_ind0_pull: assert property ((cfg_wr && cfg_addr == `ADDR_IND0_PD)
      |-> ##2 ind0_pd_en == $past(cfg_wdata[`IND0_BIT], 2))
      else $error("indicator 0 pull-down not applied");
   a_sense_dir: assert property ((cfg_wr && cfg_addr == `ADDR_SENSE_DIR)
      |-> ##2 sense_oe == $past(cfg_wdata[`SENSE_MSB:0], 2))
      else $error("sense direction not applied");
   a_sense_data: assert property ((cfg_wr && cfg_addr == `ADDR_SENSE_OUT)
      |-> ##2 sense_out == $past(cfg_wdata[`SENSE_MSB:0], 2))
      else $error("sense output data not applied");
   a_led_drive: assert property ($past(r.ind1_ctl2[`FUNC_BIT])
      |-> ind1_oe && ind1_out == ($past(pif1.wave) ^ $past(r.ind1_ctl1[`POL_BIT])))
      else $error("indicator 1 LED drive wrong");
   a_pio_release: assert property (!$past(r.ind1_ctl2[`FUNC_BIT]) |-> !ind1_oe)
      else $error("indicator 1 driven in plain io mode");
   a_led_ignores: assert property ($past(r.ind0_ctl2[`FUNC_BIT])
      |-> ind0_oe && ind0_out == ($past(pif0.wave) ^ $past(r.ind0_ctl1[`POL_BIT])))
      else $error("indicator 0 output bit leaked into LED mode");
   a_pio_data: assert property (!$past(r.ind0_ctl2[`FUNC_BIT])
      |-> ind0_oe == $past(r.ind0_dir[`IND0_BIT])
          && ind0_out == $past(r.ind0_dat[`IND0_BIT]))
      else $error("indicator 0 plain io drive wrong");
endmodule : led_pin_io
`default_nettype wire

// *** sim/pin_partner.sv ***
// external circuit on a group of device pins: drive, pull-down or float
`timescale 1ns/1ps
`default_nettype none
module pin_partner #(
   parameter int W = 1
) (
   // clock
   input wire logic sys_clk,
   // device side
   input wire logic [W-1:0] drv,
   input wire logic [W-1:0] oe,
   input wire logic [W-1:0] pd_en,
   // wire level
   output logic [W-1:0] lvl
);
   logic [W-1:0] last_r = '0;
   // a floating pin never shows a stale level: it flips every cycle
   always_comb begin
      for (int i = 0; i < W; i++) begin
         lvl[i] = oe[i] ? drv[i] : (pd_en[i] ? 1'b0 : ~last_r[i]);
      end
   end
   // an unknown level is remembered as low so that a float still flips
   always_ff @(posedge sys_clk) begin
      for (int i = 0; i < W; i++) begin
         last_r[i] <= (lvl[i] === 1'b1);
      end
   end
endmodule : pin_partner
`default_nettype wire

// *** sim/led_pin_io_tb.sv ***
// self-checking bench for the indicator pattern and pin block
`timescale 1ns/1ps
`default_nettype none
`include "led_pin_consts.svh"
module led_pin_io_tb;
   import led_pin_pkg::*;
   localparam int TK = 8;
   // half blink period at period field 2
   localparam int HB = 2 * TK;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   addr_t cfg_addr = '0;
   byte_t cfg_wdata = '0;
   logic cfg_wr = 1'b0;
   logic cfg_rd = 1'b0;
   byte_t cfg_rdata;
   logic cfg_rvalid;
   sense_vec_t sense_out, sense_oe, sense_pd_en, sense_lvl;
   logic ind0_out, ind0_oe, ind0_pd_en, ind1_out, ind1_oe;
   logic [1:0] ind_lvl;
   int n_errors = 0;
   int num_checks = 0;
   int seed = 21;
   int ncyc = 0;
   int t_wr = 0;
   byte_t mdl [addr_t];
   addr_t regs [10] = '{`ADDR_IND0_CTL1, `ADDR_IND0_CTL2, `ADDR_IND1_CTL1, `ADDR_IND1_CTL2,
      `ADDR_SENSE_PD, `ADDR_IND0_PD, `ADDR_SENSE_DIR, `ADDR_IND0_DIR, `ADDR_SENSE_OUT,
      `ADDR_IND0_OUT};

   led_pin_io #(.TICK_CYCLES(`PRESC_W'(TK))) i_led_pin_io (
      .sys_clk(sys_clk), .rst_n(rst_n), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
      .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
      .sense_out(sense_out), .sense_oe(sense_oe), .sense_pd_en(sense_pd_en),
      .ind0_out(ind0_out), .ind0_oe(ind0_oe), .ind0_pd_en(ind0_pd_en),
      .ind1_out(ind1_out), .ind1_oe(ind1_oe));
   pin_partner #(.W(5)) i_pin_partner (.sys_clk(sys_clk), .drv(sense_out), .oe(sense_oe),
      .pd_en(sense_pd_en), .lvl(sense_lvl));
   // indicator 1 has no pull-down of its own
   pin_partner #(.W(2)) i_pin_partner_ind (.sys_clk(sys_clk), .drv({ind1_out, ind0_out}),
      .oe({ind1_oe, ind0_oe}), .pd_en({1'b0, ind0_pd_en}), .lvl(ind_lvl));

   initial begin
      forever #5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      ncyc <= ncyc + 1;
   end

   ///////////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input byte_t seen, input byte_t exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic wr(input addr_t a, input byte_t d);
      cfg_addr = a;
      cfg_wdata = d;
      cfg_wr = 1'b1;
      @(posedge sys_clk);
      #1;
      t_wr = ncyc;
      cfg_wr = 1'b0;
      // unmapped writes are dropped by the model as well
      if (mdl.exists(a)) mdl[a] = d;
      @(posedge sys_clk);
      #1;
   endtask : wr

   task automatic rd(input addr_t a);
      cfg_addr = a;
      cfg_rd = 1'b1;
      @(posedge sys_clk);
      #1;
      cfg_rd = 1'b0;
      chk("rvalid", {7'h00, cfg_rvalid}, 8'h01);
      chk("rdata", cfg_rdata, mdl.exists(a) ? mdl[a] : 8'h00);
      @(posedge sys_clk);
      #1;
      chk("rvalid_end", {7'h00, cfg_rvalid}, 8'h00);
   endtask : rd

   task automatic wait_to(input int k);
      while (ncyc < t_wr + k) begin
         @(posedge sys_clk);
         #1;
      end
   endtask : wait_to

   // samples in mid phase so a cycle of start latency cannot flip the verdict
   task automatic blink_chk(input int nph, input logic pol);
      for (int n = 0; n < nph; n++) begin
         wait_to(3 + HB * n + TK);
         chk("blink", {7'h00, ind_lvl[0]}, {7'h00, ~n[0] ^ pol});
      end
   endtask : blink_chk

   task automatic watch(input int i, input int a, input int b, output int hi, output int tg);
      logic prev;
      hi = 0;
      tg = 0;
      wait_to(a);
      prev = ind_lvl[i];
      while (ncyc < t_wr + b) begin
         @(posedge sys_clk);
         #1;
         hi += (ind_lvl[i] === 1'b1);
         tg += (ind_lvl[i] !== prev);
         prev = ind_lvl[i];
      end
   endtask : watch

   task automatic pin_chk();
      byte_t d, o, p;
      d = mdl[`ADDR_SENSE_DIR] & 8'h1F;
      o = mdl[`ADDR_SENSE_OUT];
      p = mdl[`ADDR_SENSE_PD] & 8'h1F;
      chk("sense_oe", {3'h0, sense_oe}, d);
      chk("sense_pd", {3'h0, sense_pd_en}, p);
      chk("sense_lvl", {3'h0, sense_lvl & (sense_oe | sense_pd_en)}, o & d);
      d = mdl[`ADDR_IND0_DIR] & 8'h01;
      o = mdl[`ADDR_IND0_OUT];
      p = mdl[`ADDR_IND0_PD] & 8'h01;
      chk("ind0_oe", {7'h00, ind0_oe}, d);
      chk("ind0_pd", {7'h00, ind0_pd_en}, p);
      chk("ind0_lvl", {7'h00, ind_lvl[0] & (ind0_oe | ind0_pd_en)}, o & d);
      chk("ind1_plain", {6'h00, ind1_oe, ind1_out}, 8'h00);
   endtask : pin_chk

   task automatic report_and_stop();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : report_and_stop

   initial begin
      #200us;
      n_errors++;
      report_and_stop();
   end

   ///////////////////////////////////////////////////////////////////////////////////////
   initial begin
      byte_t b;
      int hi, tg;
      repeat (6) @(posedge sys_clk);
      #1;
      rst_n = 1'b1;
      @(posedge sys_clk);
      #1;
      foreach (regs[j]) mdl[regs[j]] = `RST_BYTE;
      foreach (regs[j]) rd(regs[j]);
      pin_chk();
      wr(16'h0810, 8'h5A);
      rd(16'h0810);
      rd(16'h0000);
      wr(`ADDR_IND0_PD, 8'hA5);
      rd(`ADDR_IND0_PD);
      // random settings in plain io mode; run and function bits kept clear
      for (int r = 0; r < 6; r++) begin
         foreach (regs[j]) begin
            b = byte_t'($random(seed));
            if (regs[j] == `ADDR_IND0_CTL2 || regs[j] == `ADDR_IND1_CTL2) b = b & 8'hFC;
            wr(regs[j], b);
         end
         foreach (regs[j]) rd(regs[j]);
         pin_chk();
      end
      // indicator 0 blinking, inverted, with its plain io bytes against it
      wr(`ADDR_IND0_OUT, 8'hFF);
      wr(`ADDR_IND0_DIR, 8'h00);
      wr(`ADDR_IND0_CTL1, 8'h82);
      wr(`ADDR_IND0_CTL2, 8'h03);
      blink_chk(4, 1'b1);
      chk("ind0_led_oe", {7'h00, ind0_oe}, 8'h01);
      wait_to(3 + HB + 4);
      wr(`ADDR_IND0_CTL2, 8'h01);
      watch(0, 4, 40, hi, tg);
      chk("stop_now", byte_t'(hi), 8'h24);
      wr(`ADDR_IND0_CTL2, 8'h03);
      blink_chk(2, 1'b1);
      wr(`ADDR_IND0_CTL2, 8'h0D);
      watch(0, 4, 44, hi, tg);
      chk("trail_blink", byte_t'(tg >= 2), 8'h01);
      watch(0, 60, 120, hi, tg);
      chk("trail_done", byte_t'(hi), 8'h3C);
      // indicator 1 breathing: 40 ticks of breath, 20 ticks of sleep
      wr(`ADDR_IND1_CTL1, 8'h42);
      wr(`ADDR_IND1_CTL2, 8'h07);
      watch(1, 70, 260, hi, tg);
      chk("breath_on", byte_t'(hi > 0), 8'h01);
      watch(1, 343, 463, hi, tg);
      chk("breath_sleep", byte_t'(hi), 8'h00);
      watch(1, 550, 700, hi, tg);
      chk("breath_again", byte_t'(hi > 0), 8'h01);
      wr(`ADDR_IND1_CTL2, 8'h05);
      watch(1, 5, 200, hi, tg);
      chk("breath_stop", byte_t'(hi), 8'h00);
      wr(`ADDR_IND0_CTL2, 8'h00);
      wr(`ADDR_IND1_CTL2, 8'h00);
      wait_to(4);
      pin_chk();
      report_and_stop();
   end
endmodule : led_pin_io_tb
`default_nettype wire
